// ### rtl/tcu_params.svh
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH

`define TCU_BOTTOM      8'h00
`define TCU_MAX         8'hff
`define TCU_PRESC_W     10
`define TCU_CS_STOP     3'h0
`define TCU_WGM_NORMAL  3'h0
`define TCU_WGM_PC_FF   3'h1
`define TCU_WGM_CTC     3'h2
`define TCU_WGM_FAST_FF 3'h3
`define TCU_WGM_PC_OCA  3'h5
`define TCU_WGM_FAST_OCA 3'h7
`define TCU_FLAG_OVF    0
`define TCU_FLAG_MA     1
`define TCU_FLAG_MB     2
`define TCU_FLAG_RST    3'h0

`endif

// ### rtl/tcu_pkg.sv
package tcu_pkg;

  typedef struct packed {
    logic       power_off_timer_bit;
    logic       async_clock_select;
    logic [2:0] clock_source_select;
    logic [2:0] waveform_mode_select;
  } tcu_cfg_t;

  typedef struct packed {
    logic [7:0] wdata;
    logic       count_wr;
    logic       cmp_a_wr;
    logic       cmp_b_wr;
    logic [2:0] flag_clr;
  } tcu_cpu_t;

  typedef struct packed {
    logic       top;
    logic       bottom;
    logic       match_a;
    logic       match_b;
  } tcu_wave_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic       osc_d;
    logic       osc_dd;
  } tcu_pre_st_t;

  typedef struct packed {
    logic [7:0] timer_count;
    logic [7:0] cmp_a_act;
    logic [7:0] cmp_b_act;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic       down;
    logic       block;
    logic       ma_d;
    logic       mb_d;
    logic [2:0] flags;
  } tcu_st_t;

endpackage

// ### rtl/tcu_prescaler.sv
`timescale 1ns/1ps
`include "tcu_params.svh"

module tcu_prescaler (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire tcu_pkg::tcu_cfg_t   cfg,
  input  wire logic                osc_pin_in,
  output logic                     timer_clock_tick
);
  import tcu_pkg::*;

  tcu_pre_st_t st_ff;
  tcu_pre_st_t nxt_st;
  logic        run;
  logic        src_edge;

  // -----------------------------------------------------------------
  // Prescaler and clock select
  // -----------------------------------------------------------------
  // The oscillator pin is taken as synchronous; a rising edge is one tick of the source.
  assign run = !cfg.power_off_timer_bit && (cfg.clock_source_select != `TCU_CS_STOP);

  assign src_edge = cfg.async_clock_select ? (st_ff.osc_d && !st_ff.osc_dd) : 1'b1;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.osc_d  = osc_pin_in;
    nxt_st.osc_dd = st_ff.osc_d;
    if (run && src_edge) begin
      nxt_st.cnt = st_ff.cnt + 10'h001;
    end
  end

  always_comb begin
    timer_clock_tick = 1'b0;
    if (run && src_edge) begin
      case (cfg.clock_source_select)
        3'h1:    timer_clock_tick = 1'b1;
        3'h2:    timer_clock_tick = (st_ff.cnt[2:0] == 3'h7);
        3'h3:    timer_clock_tick = (st_ff.cnt[4:0] == 5'h1f);
        3'h4:    timer_clock_tick = (st_ff.cnt[5:0] == 6'h3f);
        3'h5:    timer_clock_tick = (st_ff.cnt[6:0] == 7'h7f);
        3'h6:    timer_clock_tick = (st_ff.cnt[7:0] == 8'hff);
        3'h7:    timer_clock_tick = (st_ff.cnt == 10'h3ff);
        default: timer_clock_tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  stop_no_tick_a: assert property (@(posedge clock) disable iff (!nrst)
    (cfg.clock_source_select == `TCU_CS_STOP) |-> !timer_clock_tick)
    else $error("tick while no clock source selected");

endmodule // tcu_prescaler

// ### rtl/tcu_compare.sv
`timescale 1ns/1ps
`include "tcu_params.svh"

module tcu_compare #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] timer_count,
  input  wire logic [WIDTH-1:0] cmp_a,
  input  wire logic [WIDTH-1:0] cmp_b,
  output logic      [1:0]       match
);

  // -----------------------------------------------------------------
  // Comparators
  // -----------------------------------------------------------------
  // continuous compare
  assign match[0] = (timer_count == cmp_a);
  assign match[1] = (timer_count == cmp_b);

endmodule // tcu_compare

// ### rtl/tcu_counter_unit.sv
`timescale 1ns/1ps
`include "tcu_params.svh"


module tcu_counter_unit (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire tcu_pkg::tcu_cfg_t  cfg,
  input  wire tcu_pkg::tcu_cpu_t  cpu,
  input  wire logic [2:0]         timer_mask_reg,
  input  wire logic [2:0]         irq_ack,
  input  wire logic               osc_pin_in,
  output logic      [7:0]         timer_count,
  output logic      [7:0]         compare_value_a,
  output logic      [7:0]         compare_value_b,
  output logic      [2:0]         timer_flag_reg,
  output logic      [2:0]         irq_req,
  output logic                    timer_clock_tick,
  output tcu_pkg::tcu_wave_t      wave
);
  import tcu_pkg::*;

  tcu_st_t    st_ff;
  tcu_st_t    nxt_st;
  logic [1:0] match;
  logic [7:0] top_val;
  logic       pwm;
  logic       dual;
  logic       at_top;
  logic       at_bottom;
  logic       ovf_ev;
  logic [2:0] set_ev;
  logic [2:0] clr_ev;

  // -----------------------------------------------------------------
  // Clock select and comparators
  // -----------------------------------------------------------------
  tcu_prescaler u_pre (
    .clock            (clock),
    .nrst             (nrst),
    .cfg              (cfg),
    .osc_pin_in       (osc_pin_in),
    .timer_clock_tick (timer_clock_tick)
  );

  tcu_compare #(.WIDTH(8)) u_cmp (
    .timer_count (st_ff.timer_count),
    .cmp_a       (st_ff.cmp_a_act),
    .cmp_b       (st_ff.cmp_b_act),
    .match       (match)
  );

  // -----------------------------------------------------------------
  // Mode decode
  // -----------------------------------------------------------------
  // mode field decode
  assign pwm  = (cfg.waveform_mode_select != `TCU_WGM_NORMAL)
             && (cfg.waveform_mode_select != `TCU_WGM_CTC);
  assign dual = (cfg.waveform_mode_select == `TCU_WGM_PC_FF)
             || (cfg.waveform_mode_select == `TCU_WGM_PC_OCA);

  always_comb begin
    case (cfg.waveform_mode_select)
      `TCU_WGM_CTC, `TCU_WGM_PC_OCA, `TCU_WGM_FAST_OCA: top_val = st_ff.cmp_a_act;
      default:                                           top_val = `TCU_MAX;
    endcase
  end

  assign at_top    = (st_ff.timer_count == top_val);
  assign at_bottom = (st_ff.timer_count == `TCU_BOTTOM);
  assign wave.top     = at_top;
  assign wave.bottom  = at_bottom;
  assign wave.match_a = match[0] && !st_ff.block;
  assign wave.match_b = match[1] && !st_ff.block;

  // -----------------------------------------------------------------
  // Counter, buffers and flags
  // -----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    ovf_ev = 1'b0;
    set_ev = 3'h0;
    clr_ev = cpu.flag_clr | irq_ack;
    if (timer_clock_tick) begin
      nxt_st.block = 1'b0;
      nxt_st.ma_d  = wave.match_a;
      nxt_st.mb_d  = wave.match_b;
      // The flag rises on the tick that leaves the matching count, never a tick later.
      // match sets flag
      set_ev[`TCU_FLAG_MA] = wave.match_a;
      set_ev[`TCU_FLAG_MB] = wave.match_b;
      if (dual) begin
        if (st_ff.down) begin
          nxt_st.timer_count = st_ff.timer_count - 8'h01;
          if (st_ff.timer_count == 8'h01) begin
            nxt_st.down = 1'b0;
          end
        end else begin
          nxt_st.timer_count = st_ff.timer_count + 8'h01;
          if (st_ff.timer_count + 8'h01 == top_val) begin
            nxt_st.down = 1'b1;
          end
        end
        ovf_ev = at_bottom;
      end else if (at_top) begin
        nxt_st.timer_count = `TCU_BOTTOM;
        nxt_st.down        = 1'b0;
        ovf_ev = (cfg.waveform_mode_select == `TCU_WGM_NORMAL)
              || (cfg.waveform_mode_select == `TCU_WGM_CTC) ? (top_val == `TCU_MAX) : 1'b1;
      end else begin
        nxt_st.timer_count = st_ff.timer_count + 8'h01;
        // A CTC count written above top runs on to max and overflows there.
        // overrun at max
        ovf_ev = !pwm && (st_ff.timer_count == `TCU_MAX);
      end
      // Both PWM flavours reload at top, where the dual slope has already turned.
      // buffered update at top
      if (pwm && at_top) begin
        nxt_st.cmp_a_act = st_ff.cmp_a_buf;
        nxt_st.cmp_b_act = st_ff.cmp_b_buf;
      end
    end
    set_ev[`TCU_FLAG_OVF] = ovf_ev;
    if (cpu.cmp_a_wr) begin
      nxt_st.cmp_a_buf = cpu.wdata;
      if (!pwm) begin
        nxt_st.cmp_a_act = cpu.wdata;
      end
    end
    if (cpu.cmp_b_wr) begin
      nxt_st.cmp_b_buf = cpu.wdata;
      if (!pwm) begin
        nxt_st.cmp_b_act = cpu.wdata;
      end
    end
    if (cpu.count_wr) begin
      nxt_st.timer_count = cpu.wdata;
      nxt_st.block       = 1'b1;
      nxt_st.ma_d        = 1'b0;
      nxt_st.mb_d        = 1'b0;
    end
    nxt_st.flags = (st_ff.flags & ~clr_ev) | set_ev;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign timer_count     = st_ff.timer_count;
  assign compare_value_a = st_ff.cmp_a_buf;
  assign compare_value_b = st_ff.cmp_b_buf;
  assign timer_flag_reg  = st_ff.flags;
  assign irq_req         = st_ff.flags & timer_mask_reg;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  sequence s_write;
    cpu.count_wr;
  endsequence

  // A tick that no count write overrides.
  sequence s_tick_free;
    timer_clock_tick && !cpu.count_wr;
  endsequence

  sequence s_write_tick;
    cpu.count_wr ##1 timer_clock_tick;
  endsequence

  count_write_wins_a: assert property (@(posedge clock) disable iff (!nrst)
    s_write |=> (timer_count == $past(cpu.wdata)))
    else $error("count write did not take priority");

  hold_when_stopped_a: assert property (@(posedge clock) disable iff (!nrst)
    (!timer_clock_tick && !cpu.count_wr) |=> $stable(timer_count))
    else $error("count changed without a tick");

  normal_up_a: assert property (@(posedge clock) disable iff (!nrst)
    (timer_clock_tick && !cpu.count_wr && cfg.waveform_mode_select == `TCU_WGM_NORMAL)
    |=> (timer_count == $past(timer_count) + 8'h01))
    else $error("normal mode did not increment");

  normal_ovf_a: assert property (@(posedge clock) disable iff (!nrst)
    (timer_clock_tick && cfg.waveform_mode_select == `TCU_WGM_NORMAL
     && timer_count == `TCU_MAX) |=> timer_flag_reg[`TCU_FLAG_OVF])
    else $error("overflow flag missing on wrap");

  match_flag_a_a: assert property (@(posedge clock) disable iff (!nrst)
    (s_tick_free ##0 wave.match_a) |=> (timer_flag_reg[`TCU_FLAG_MA] && st_ff.ma_d))
    else $error("match flag A not set on the tick after the match");

  write_blocks_a: assert property (@(posedge clock) disable iff (!nrst)
    s_write |=> (!wave.match_a && !wave.match_b))
    else $error("match not blocked after count write");

  flag_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (cpu.flag_clr[`TCU_FLAG_OVF] && !set_ev[`TCU_FLAG_OVF])
    |=> !timer_flag_reg[`TCU_FLAG_OVF])
    else $error("overflow flag not cleared by write of one");

  irq_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    irq_req == (timer_flag_reg & timer_mask_reg))
    else $error("request line disagrees with flag and mask");

  ctc_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (timer_clock_tick && !cpu.count_wr && cfg.waveform_mode_select == `TCU_WGM_CTC
     && timer_count == st_ff.cmp_a_act) |=> (timer_count == `TCU_BOTTOM))
    else $error("CTC did not clear at compare A");

  match_flag_b_a: assert property (@(posedge clock) disable iff (!nrst)
    (s_tick_free ##0 wave.match_b) |=> (timer_flag_reg[`TCU_FLAG_MB] && st_ff.mb_d))
    else $error("match flag B not set on the tick after the match");

  // The block must last exactly one tick; a longer one would swallow real matches.
  block_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (timer_clock_tick && !cpu.count_wr) |=> !st_ff.block)
    else $error("match block outlived its tick");

  write_tick_no_set_a: assert property (@(posedge clock) disable iff (!nrst)
    s_write_tick |=> (!$rose(timer_flag_reg[`TCU_FLAG_MA])
                      && !$rose(timer_flag_reg[`TCU_FLAG_MB])))
    else $error("match flag set by a blocked tick");

  power_off_a: assert property (@(posedge clock) disable iff (!nrst)
    cfg.power_off_timer_bit |-> !timer_clock_tick)
    else $error("tick while the timer is powered off");

  down_count_a: assert property (@(posedge clock) disable iff (!nrst)
    (s_tick_free ##0 (dual && st_ff.down))
    |=> (timer_count == $past(timer_count) - 8'h01))
    else $error("dual slope did not decrement");

  // Overflow points differ per waveform family, so normal, phase correct and fast PWM each have their own check; CTC has none.
  pc_overflow_a: assert property (@(posedge clock) disable iff (!nrst)
    (timer_clock_tick && dual && wave.bottom) |=> timer_flag_reg[`TCU_FLAG_OVF])
    else $error("overflow flag missing at bottom");

  fast_overflow_a: assert property (@(posedge clock) disable iff (!nrst)
    (timer_clock_tick && pwm && !dual && wave.top) |=> timer_flag_reg[`TCU_FLAG_OVF])
    else $error("overflow flag missing at top");

  cmp_direct_a: assert property (@(posedge clock) disable iff (!nrst)
    (cpu.cmp_a_wr && !pwm) |=> (st_ff.cmp_a_act == $past(cpu.wdata)))
    else $error("compare A not written through outside PWM");

  buffer_load_a: assert property (@(posedge clock) disable iff (!nrst)
    (timer_clock_tick && pwm && wave.top) |=> (st_ff.cmp_a_act == $past(st_ff.cmp_a_buf)))
    else $error("compare A buffer not loaded at top");

  // Set beats clear, and a flag only falls on a clear; tests seldom land on the overlap.
  set_wins_a: assert property (@(posedge clock) disable iff (!nrst)
    (set_ev != 3'h0) |=> ((timer_flag_reg & $past(set_ev)) == $past(set_ev)))
    else $error("flag set lost against a clear");

  flag_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (clr_ev == 3'h0)
    |=> ((timer_flag_reg & $past(timer_flag_reg)) == $past(timer_flag_reg)))
    else $error("flag fell without a clear");

endmodule // tcu_counter_unit

// ### testbench/tcu_counter_unit_tb_top.sv
`timescale 1ns/1ps

module tcu_counter_unit_tb_top;
  import tcu_pkg::*;

  logic       clock;
  logic       nrst;
  tcu_cfg_t   cfg;
  tcu_cpu_t   cpu;
  logic [2:0] mask;
  logic [2:0] ack;
  logic       osc;
  logic [7:0] count;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic [2:0] flags;
  logic [2:0] irq;
  logic       tick;
  tcu_wave_t  wave;
  int         errors;
  int         check_count;
  int         n;
  logic [7:0] c;
  int         divs [7] = '{1, 8, 32, 64, 128, 256, 1024};

  tcu_counter_unit DUT (
    .clock(clock), .nrst(nrst), .cfg(cfg), .cpu(cpu), .timer_mask_reg(mask),
    .irq_ack(ack), .osc_pin_in(osc), .timer_count(count), .compare_value_a(cmp_a),
    .compare_value_b(cmp_b), .timer_flag_reg(flags), .irq_req(irq),
    .timer_clock_tick(tick), .wave(wave));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // The tests need about 20000 cycles; the limit leaves a wide margin.
  initial begin
    #600000;
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    finish_test();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  // Callers stand at a falling edge; the strobe covers exactly one rising edge.
  // Only the chosen strobe is touched, so back-to-back calls never assign one twice.
  task automatic wr(input int sel, input logic [7:0] v);
    cpu.wdata = v;
    case (sel)
      0:       cpu.count_wr = 1'b1;
      1:       cpu.cmp_a_wr = 1'b1;
      default: cpu.cmp_b_wr = 1'b1;
    endcase
    cyc(1);
    case (sel)
      0:       cpu.count_wr = 1'b0;
      1:       cpu.cmp_a_wr = 1'b0;
      default: cpu.cmp_b_wr = 1'b0;
    endcase
  endtask

  task automatic wait_count(input logic [7:0] v);
    n = 0;
    while (count !== v && n < 600) begin
      cyc(1);
      n++;
    end
    chk8(count, v, "count reached");
  endtask

  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    errors = 0;
    check_count = 0;
    cfg = '0;
    cpu = '0;
    mask = 3'h0;
    ack = 3'h0;
    osc = 1'b0;
    nrst = 1'b0;
    cyc(4);
    nrst = 1'b1;
    chk8(count, 8'h00, "count reset");
    chk8({5'h0, flags}, 8'h00, "flags reset");
    chk8({5'h0, irq}, 8'h00, "irq reset");
    wr(0, 8'h5a);
    chk8(count, 8'h5a, "stopped write");
    cyc(20);
    chk8(count, 8'h5a, "stopped hold");
    cfg.power_off_timer_bit = 1'b1;
    cfg.clock_source_select = 3'h1;
    cyc(20);
    chk8(count, 8'h5a, "power off hold");
    cfg.power_off_timer_bit = 1'b0;
    cyc(3);
    wr(0, 8'h80);
    chk8(count, 8'h80, "write beats tick");
    c = count;
    cyc(1);
    chk8(count, c + 8'h01, "increment");
    for (int i = 0; i < 2; i++) begin
      wr(0, 8'hfc);
      wait_count(8'hff);
      chk8({7'h0, wave.top}, 8'h01, "top at max");
      cyc(1);
      chk8(count, 8'h00, "wrap");
      chk8({7'h0, flags[0]}, 8'h01, "overflow on wrap");
      chk8({7'h0, wave.bottom}, 8'h01, "bottom");
      mask = 3'h1;
      #1;
      chk8({5'h0, irq}, 8'h01, "irq masked in");
      mask = 3'h0;
      #1;
      chk8({5'h0, irq}, 8'h00, "irq masked out");
      cyc(1);
      // The pass through zero also matched both compare values, still zero here.
      if (i == 0) begin
        cpu.flag_clr = 3'h7;
      end else begin
        ack = 3'h7;
      end
      cyc(1);
      cpu.flag_clr = 3'h0;
      ack = 3'h0;
      chk8({5'h0, flags}, 8'h00, "flags cleared");
    end
    cfg.waveform_mode_select = 3'h2;
    wr(1, 8'h10);
    wr(2, 8'h12);
    chk8(cmp_a, 8'h10, "compare a");
    chk8(cmp_b, 8'h12, "compare b");
    wr(0, 8'h0c);
    wait_count(8'h10);
    chk8({7'h0, flags[1]}, 8'h00, "match a early");
    cyc(1);
    chk8(count, 8'h00, "clear at compare a");
    chk8({7'h0, flags[1]}, 8'h01, "match a on next tick");
    cyc(1);
    chk8({6'h0, flags[2:1]}, 8'h01, "match a flag only");
    cpu.flag_clr = 3'h7;
    cfg.clock_source_select = 3'h0;
    cfg.waveform_mode_select = 3'h0;
    cyc(1);
    cpu.flag_clr = 3'h0;
    wr(0, 8'h12);
    cyc(2);
    cfg.clock_source_select = 3'h1;
    cyc(4);
    chk8({7'h0, flags[2]}, 8'h00, "match blocked");
    cfg.clock_source_select = 3'h0;
    wr(0, 8'h11);
    cfg.clock_source_select = 3'h1;
    cyc(4);
    chk8({7'h0, flags[2]}, 8'h01, "match b flag");
    cfg.waveform_mode_select = 3'h1;
    wr(0, 8'hfd);
    wait_count(8'hff);
    cyc(1);
    chk8(count, 8'hfe, "count down");
    wait_count(8'h00);
    cyc(1);
    chk8({7'h0, flags[0]}, 8'h01, "overflow at bottom");
    cfg.waveform_mode_select = 3'h0;
    cfg.async_clock_select = 1'b1;
    c = count;
    cyc(10);
    chk8(count, c, "no oscillator edge");
    repeat (4) begin
      osc = 1'b1;
      cyc(3);
      osc = 1'b0;
      cyc(3);
    end
    chk8(count, c + 8'h04, "oscillator ticks");
    cfg.async_clock_select = 1'b0;
    for (int i = 0; i < 7; i++) begin
      cfg.clock_source_select = 3'(i + 1);
      cyc(1024);
      n = 0;
      repeat (divs[i] * 8) begin
        cyc(1);
        if (tick === 1'b1) begin
          n++;
        end
      end
      chk8(n[7:0], 8'h08, "prescaler ticks");
    end
    finish_test();
  end

endmodule // tcu_counter_unit_tb_top
